// ===== verilog/sync_source_select.v
// sync source selection with axi4-lite register access
// assumes one aclk domain; ext_sync, input_strobe, output_strobe asynchronous
//
// Operation
// - ab mixer mask 15:12: sw sync, ext sync, out strobe, auto; reset 0001
// - cd mixer mask 11:8 uses the same per-bit source mapping
// - several mask bits may be set; any enabled source triggers sync
// - nco mask 7:4: sw sync, ext sync, out strobe, in strobe; reset 0100
// - route field 3:2: codes 00/10 pass input strobe, 01/11 ext sync
// - routing applies only while fifo input mask equals 0010
// - sw sync bit 1 asserts sync while 1; software clears it
// - fifo output mask: 11 sw, 10 out strobe, 9 in strobe, 8 ext
// - fifo output pointer sync only while divider sync enable is set
// - divider select 0 uses out strobe, 1 uses fifo input selection
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sync_select_defines.vh"

module sync_source_select (
   input  wire                 aclk,
   input  wire                 aresetn,
   // axi4-lite slave
   input  wire [`ADDR_W+1:0]   s_axi_awaddr,
   input  wire                 s_axi_awvalid,
   output wire                 s_axi_awready,
   input  wire [31:0]          s_axi_wdata,
   input  wire [3:0]           s_axi_wstrb,
   input  wire                 s_axi_wvalid,
   output wire                 s_axi_wready,
   output wire [1:0]           s_axi_bresp,
   output wire                 s_axi_bvalid,
   input  wire                 s_axi_bready,
   input  wire [`ADDR_W+1:0]   s_axi_araddr,
   input  wire                 s_axi_arvalid,
   output wire                 s_axi_arready,
   output wire [31:0]          s_axi_rdata,
   output wire [1:0]           s_axi_rresp,
   output wire                 s_axi_rvalid,
   input  wire                 s_axi_rready,
   // external sync pins
   input  wire                 ext_sync,
   input  wire                 input_strobe,
   input  wire                 output_strobe,
   // double-buffered mixer values
   input  wire [15:0]          mixer_ab_pending,
   input  wire [15:0]          mixer_cd_pending,
   output wire [15:0]          mixer_ab_active,
   output wire [15:0]          mixer_cd_active,
   // sync distribution
   output wire                 mixer_ab_sync,
   output wire                 mixer_cd_sync,
   output wire                 nco_sync,
   output wire                 fifo_in_sync,
   output wire                 fifo_out_sync,
   output wire                 clkdiv_sync,
   output wire                 fifo_input_strobe_path
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function [1:0] decode;
      input [`ADDR_W+1:0] addr;
      begin
         case (addr[`ADDR_W+1:2])
            `IDX_MIXER_NCO:    decode = 2'h0;
            `IDX_FIFO_DIVIDER: decode = 2'h1;
            `IDX_SYNC_CONTROL: decode = 2'h2;
            `IDX_SYNC_STATUS:  decode = 2'h3;
            default:           decode = 2'h3;
         endcase
      end
   endfunction

   function mapped;
      input [`ADDR_W+1:0] addr;
      begin
         mapped = (addr[`ADDR_W+1:2] == `IDX_MIXER_NCO) ||
                  (addr[`ADDR_W+1:2] == `IDX_FIFO_DIVIDER) ||
                  (addr[`ADDR_W+1:2] == `IDX_SYNC_CONTROL) ||
                  (addr[`ADDR_W+1:2] == `IDX_SYNC_STATUS);
      end
   endfunction

   // byte-lane merge limited to the writable bits
   function [15:0] merge;
      input [15:0] old;
      input [15:0] wdata;
      input [1:0]  strb;
      input [15:0] rw_mask;
      reg   [15:0] lanes;
      begin
         lanes = {{8{strb[1]}}, {8{strb[0]}}} & rw_mask;
         merge = (old & ~lanes) | (wdata & lanes);
      end
   endfunction

   // masked or of four source events
   function any_source;
      input [3:0] mask;
      input [3:0] events;
      begin
         any_source = |(mask & events);
      end
   endfunction

   // ---------------------------------------------------------------
   // registers and state
   // ---------------------------------------------------------------
   reg [15:0]          mixer_nco_q;
   reg [15:0]          fifo_divider_q;
   reg [15:0]          sync_control_q;
   reg                 aw_got_q;
   reg                 w_got_q;
   reg [`ADDR_W+1:0]   awaddr_q;
   reg [31:0]          wdata_q;
   reg [3:0]           wstrb_q;
   reg                 bvalid_q;
   reg [1:0]           bresp_q;
   reg                 rvalid_q;
   reg [31:0]          rdata_q;
   reg [1:0]           rresp_q;
   reg                 auto_sync_q;
   reg [15:0]          mixer_ab_active_q;
   reg [15:0]          mixer_cd_active_q;
   reg                 mixer_ab_sync_q;
   reg                 mixer_cd_sync_q;
   reg                 nco_sync_q;
   reg                 fifo_in_sync_q;
   reg                 fifo_out_sync_q;
   reg                 clkdiv_sync_q;
   reg                 fifo_path_q;
   reg [15:0]          read_word;

   wire [2:0]          pin_level;
   wire [2:0]          pin_rise;
   wire                aw_hs;
   wire                w_hs;
   wire                ar_hs;
   wire                do_write;
   wire                sw_sync;
   wire                sync_ev;
   wire                input_strobe_ev;
   wire                output_strobe_ev;
   wire                route_ev;
   wire                mixer_ab_d;
   wire                mixer_cd_d;
   wire                nco_d;
   wire                fifo_in_d;
   wire                fifo_out_d;
   wire                clkdiv_d;
   wire [3:0]          fifo_in_mask;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   sync_edge_detect u_pins (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  ({output_strobe, input_strobe, ext_sync}),
      .level   (pin_level),
      .rise    (pin_rise)
   );

   assign sync_ev = pin_rise[0];
   assign input_strobe_ev = pin_rise[1];
   assign output_strobe_ev = pin_rise[2];
   assign sw_sync = mixer_nco_q[`SW_SYNC_BIT];

   // ---------------------------------------------------------------
   // axi4-lite write channel
   // ---------------------------------------------------------------
   assign aw_hs         = s_axi_awvalid & s_axi_awready;
   assign w_hs          = s_axi_wvalid & s_axi_wready;
   assign s_axi_awready = ~aw_got_q & ~bvalid_q;
   assign s_axi_wready  = ~w_got_q & ~bvalid_q;
   assign do_write      = aw_got_q & w_got_q & ~bvalid_q;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q       <= 1'b0;
         w_got_q        <= 1'b0;
         awaddr_q       <= {(`ADDR_W+2){1'b0}};
         wdata_q        <= 32'h0;
         wstrb_q        <= 4'h0;
         bvalid_q       <= 1'b0;
         bresp_q        <= `RESP_OKAY;
         auto_sync_q    <= 1'b0;
         mixer_nco_q    <= `RST_MIXER_NCO;
         fifo_divider_q <= `RST_FIFO_DIVIDER;
         sync_control_q <= `RST_SYNC_CONTROL;
      end else begin
         auto_sync_q <= 1'b0;
         if (aw_hs) begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (w_hs) begin
            w_got_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
            auto_sync_q <= mapped(awaddr_q) && (decode(awaddr_q) != 2'h3);
            case (decode(awaddr_q))
               2'h0: mixer_nco_q <= merge(mixer_nco_q, wdata_q[15:0],
                                          wstrb_q[1:0], `MIXER_NCO_RW_MASK);
               2'h1: if (mapped(awaddr_q)) begin
                  fifo_divider_q <= merge(fifo_divider_q, wdata_q[15:0],
                                          wstrb_q[1:0], `FIFO_DIV_RW_MASK);
               end
               2'h2: sync_control_q <= merge(sync_control_q, wdata_q[15:0],
                                             wstrb_q[1:0], `SYNC_CONTROL_RW_MASK);
               default: ;
            endcase
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   // ---------------------------------------------------------------
   // axi4-lite read channel
   // ---------------------------------------------------------------
   assign s_axi_arready = ~rvalid_q;
   assign ar_hs         = s_axi_arvalid & ~rvalid_q;

   always @* begin
      case (decode(s_axi_araddr))
         2'h0:    read_word = mixer_nco_q;
         2'h1:    read_word = fifo_divider_q;
         2'h2:    read_word = sync_control_q;
         default: read_word = {13'h0, pin_level};
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0;
         rresp_q  <= `RESP_OKAY;
      end else if (ar_hs) begin
         rvalid_q <= 1'b1;
         rdata_q  <= mapped(s_axi_araddr) ? {16'h0, read_word} : 32'h0;
         rresp_q  <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   // ---------------------------------------------------------------
   // source routing and sync distribution
   // ---------------------------------------------------------------
   assign fifo_in_mask = fifo_divider_q[`FIFO_IN_HI:`FIFO_IN_LO];
   assign route_ev = ((fifo_in_mask == `FIFO_IN_INPUT_STROBE_ONLY) &&
                      mixer_nco_q[`FIFO_ROUTE_BIT]) ? sync_ev : input_strobe_ev;

   assign mixer_ab_d = any_source(mixer_nco_q[`MIX_AB_HI:`MIX_AB_LO],
                                  {sw_sync, sync_ev, output_strobe_ev, auto_sync_q});
   assign mixer_cd_d = any_source(mixer_nco_q[`MIX_CD_HI:`MIX_CD_LO],
                                  {sw_sync, sync_ev, output_strobe_ev, auto_sync_q});
   assign nco_d      = any_source(mixer_nco_q[`NCO_HI:`NCO_LO],
                                  {sw_sync, sync_ev, output_strobe_ev, input_strobe_ev});
   assign fifo_in_d  = any_source(fifo_in_mask,
                                  {sw_sync, 1'b0, route_ev, sync_ev});
   assign fifo_out_d = sync_control_q[`CLKDIV_ENA_BIT] &
                       any_source(fifo_divider_q[`FIFO_OUT_HI:`FIFO_OUT_LO],
                                  {sw_sync, output_strobe_ev, input_strobe_ev, sync_ev});
   assign clkdiv_d   = fifo_divider_q[`CLKDIV_SEL_BIT] ? fifo_in_d : output_strobe_ev;

   always @(posedge aclk) begin
      if (!aresetn) begin
         mixer_ab_sync_q   <= 1'b0;
         mixer_cd_sync_q   <= 1'b0;
         nco_sync_q        <= 1'b0;
         fifo_in_sync_q    <= 1'b0;
         fifo_out_sync_q   <= 1'b0;
         clkdiv_sync_q     <= 1'b0;
         fifo_path_q       <= 1'b0;
         mixer_ab_active_q <= 16'h0;
         mixer_cd_active_q <= 16'h0;
      end else begin
         mixer_ab_sync_q <= mixer_ab_d;
         mixer_cd_sync_q <= mixer_cd_d;
         nco_sync_q      <= nco_d;
         fifo_in_sync_q  <= fifo_in_d;
         fifo_out_sync_q <= fifo_out_d;
         clkdiv_sync_q   <= clkdiv_d;
         fifo_path_q     <= route_ev;
         if (mixer_ab_d) begin
            mixer_ab_active_q <= mixer_ab_pending;
         end
         if (mixer_cd_d) begin
            mixer_cd_active_q <= mixer_cd_pending;
         end
      end
   end

   assign mixer_ab_sync          = mixer_ab_sync_q;
   assign mixer_cd_sync          = mixer_cd_sync_q;
   assign nco_sync               = nco_sync_q;
   assign fifo_in_sync           = fifo_in_sync_q;
   assign fifo_out_sync          = fifo_out_sync_q;
   assign clkdiv_sync            = clkdiv_sync_q;
   assign fifo_input_strobe_path = fifo_path_q;
   assign mixer_ab_active        = mixer_ab_active_q;
   assign mixer_cd_active        = mixer_cd_active_q;

endmodule // sync_source_select

`default_nettype wire

// ===== verilog/sync_select_defines.vh
// sync source selection: register map, field positions, reset values
// assumes inclusion by bare name from the design files
`ifndef SYNC_SELECT_DEFINES_VH
`define SYNC_SELECT_DEFINES_VH

// ----------------------------------------------------------------------
// register indices and byte addresses (byte address = 4 x index)
// ----------------------------------------------------------------------
`define IDX_MIXER_NCO      8'h1f
`define IDX_FIFO_DIVIDER   8'h20
`define IDX_SYNC_CONTROL   8'h30
`define IDX_SYNC_STATUS    8'h31
`define ADDR_W             8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_MIXER_NCO      16'h1140
`define RST_FIFO_DIVIDER   16'h2400
`define RST_SYNC_CONTROL   16'h0000

// ----------------------------------------------------------------------
// sync_select_mixer_nco fields
// ----------------------------------------------------------------------
`define MIX_AB_HI          15
`define MIX_AB_LO          12
`define MIX_CD_HI          11
`define MIX_CD_LO          8
`define NCO_HI             7
`define NCO_LO             4
`define FIFO_ROUTE_BIT     2
`define SW_SYNC_BIT        1
`define MIXER_NCO_RW_MASK  16'hfffe

// ----------------------------------------------------------------------
// sync_select_fifo_divider fields
// ----------------------------------------------------------------------
`define FIFO_IN_HI         15
`define FIFO_IN_LO         12
`define FIFO_OUT_HI        11
`define FIFO_OUT_LO        8
`define CLKDIV_SEL_BIT     0
`define FIFO_DIV_RW_MASK   16'hbf01
`define FIFO_IN_INPUT_STROBE_ONLY  4'h2

// ----------------------------------------------------------------------
// sync_control fields
// ----------------------------------------------------------------------
`define CLKDIV_ENA_BIT     0
`define SYNC_CONTROL_RW_MASK 16'h0001

// ----------------------------------------------------------------------
// axi responses
// ----------------------------------------------------------------------
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== verilog/sync_edge_detect.v
// two-stage synchroniser and rising-edge detector for the three sync pins
// assumes pins asynchronous to aclk
`timescale 1ns/100ps
`default_nettype none

module sync_edge_detect (
   input  wire       aclk,
   input  wire       aresetn,
   input  wire [2:0] pin_in,
   output wire [2:0] level,
   output wire [2:0] rise
);

   reg [2:0] meta_q;
   reg [2:0] stable_q;
   reg [2:0] prev_q;

   // ---------------------------------------------------------------
   // synchroniser and edge detect
   // ---------------------------------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q   <= 3'h0;
         stable_q <= 3'h0;
         prev_q   <= 3'h0;
      end else begin
         meta_q   <= pin_in;
         stable_q <= meta_q;
         prev_q   <= stable_q;
      end
   end

   assign level = stable_q;
   assign rise  = stable_q & ~prev_q;

endmodule // sync_edge_detect

`default_nettype wire

// ===== verification/sync_pin_source.sv
// far-side source model: drives the three lvds sync pins
// assumes aclk from the bench; pins change just after a rising edge
`timescale 1ns/100ps
`default_nettype none

module sync_pin_source (
   input  wire logic aclk,
   output var  logic ext_sync,
   output var  logic input_strobe,
   output var  logic output_strobe
);
   initial begin
      ext_sync = 1'b0;
      input_strobe = 1'b0;
      output_strobe = 1'b0;
   end

   // one rising edge held for width cycles, then low again
   task automatic pulse(input int idx, input int width);
      @(posedge aclk);
      case (idx)
         0: ext_sync <= 1'b1;
         1: input_strobe <= 1'b1;
         default: output_strobe <= 1'b1;
      endcase
      repeat (width) @(posedge aclk);
      {output_strobe, input_strobe, ext_sync} <= 3'b000;
   endtask
endmodule // sync_pin_source
`default_nettype wire

// ===== verification/sync_source_select_sva.sv
// checker for sync_source_select
// assumes the design's port names; attached by bind
`timescale 1ns/100ps
`default_nettype none

module sync_source_select_sva (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic [15:0] mixer_ab_pending,
   input wire logic [15:0] mixer_cd_pending,
   input wire logic [15:0] mixer_ab_active,
   input wire logic [15:0] mixer_cd_active,
   input wire logic        mixer_ab_sync,
   input wire logic        mixer_cd_sync,
   input wire logic        fifo_input_strobe_path
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   ab_load_a: assert property (mixer_ab_sync |-> mixer_ab_active == $past(mixer_ab_pending))
      else $error("ab active copy not loaded on sync");
   cd_load_a: assert property (mixer_cd_sync |-> mixer_cd_active == $past(mixer_cd_pending))
      else $error("cd active copy not loaded on sync");
   ab_hold_a: assert property (!mixer_ab_sync |-> $stable(mixer_ab_active))
      else $error("ab active copy changed without sync");
   cd_hold_a: assert property (!mixer_cd_sync |-> $stable(mixer_cd_active))
      else $error("cd active copy changed without sync");
   route_pulse_a: assert property (fifo_input_strobe_path |=> !fifo_input_strobe_path)
      else $error("routed strobe longer than one cycle");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> ##1 s_axi_bvalid)
      else $error("write response late");
   read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
endmodule // sync_source_select_sva

bind sync_source_select sync_source_select_sva u_sva (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .mixer_ab_pending(mixer_ab_pending), .mixer_cd_pending(mixer_cd_pending),
   .mixer_ab_active(mixer_ab_active), .mixer_cd_active(mixer_cd_active),
   .mixer_ab_sync(mixer_ab_sync), .mixer_cd_sync(mixer_cd_sync),
   .fifo_input_strobe_path(fifo_input_strobe_path));
`default_nettype wire

// ===== verification/test_sync_source_select.sv
// self-checking bench for sync_source_select
// assumes 200 MHz aclk, pin source model and bound checker
`timescale 1ns/100ps
`default_nettype none

module test_sync_source_select;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [9:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic [15:0] ab_pend;
   wire         awready, wready, bvalid, arready, rvalid, ext_sync, in_stb, out_stb;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [15:0] ab_act, cd_act;
   wire  [6:0]  outs;
   int          mismatches, n_compared, cnt[7], base[7];

   sync_pin_source src (.aclk(aclk), .ext_sync(ext_sync), .input_strobe(in_stb),
      .output_strobe(out_stb));
   sync_source_select dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h3), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .ext_sync(ext_sync), .input_strobe(in_stb), .output_strobe(out_stb),
      .mixer_ab_pending(ab_pend), .mixer_cd_pending(~ab_pend), .mixer_ab_active(ab_act),
      .mixer_cd_active(cd_act), .mixer_ab_sync(outs[0]), .mixer_cd_sync(outs[1]),
      .nco_sync(outs[2]), .fifo_in_sync(outs[3]), .fifo_out_sync(outs[4]),
      .clkdiv_sync(outs[5]), .fifo_input_strobe_path(outs[6]));

   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   always @(posedge aclk) begin
      for (int i = 0; i < 7; i++)
         if (outs[i] === 1'b1)
            cnt[i] += 1;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [9:0] a, input logic [15:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= {16'h0000, d};
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
      end while (awvalid || wvalid);
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      check("write resp", {30'h0, bresp}, {30'h0, er});
   endtask

   task automatic rd(input logic [9:0] a, input logic [15:0] ed, input logic [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rready <= 1'b0;
      check("read data", rdata, {16'h0000, ed});
      check("read resp", {30'h0, rresp}, {30'h0, er});
   endtask

   task automatic cmp_counts(input logic [6:0] e);
      for (int i = 0; i < 7; i++)
         check("sync count", 32'(cnt[i] - base[i]), {31'h0, e[i]});
   endtask

   function automatic logic [6:0] expect_vec(input logic [15:0] mn, input logic [15:0] fd,
                                             input logic en, input int p);
      logic e, i, o, path, fin;
      e = (p == 0);
      i = (p == 1);
      o = (p == 2);
      path = (fd[15:12] == 4'h2 && mn[2]) ? e : i;
      fin = (fd[13] & path) | (fd[12] & e);
      return {path, fd[0] ? fin : o, en & ((fd[10] & o) | (fd[9] & i) | (fd[8] & e)), fin,
              (mn[6] & e) | (mn[5] & o) | (mn[4] & i), (mn[10] & e) | (mn[9] & o),
              (mn[14] & e) | (mn[13] & o)};
   endfunction

   task automatic test_regs;
      rd(10'h07c, 16'h1140, 2'h0);
      rd(10'h080, 16'h2400, 2'h0);
      rd(10'h3fc, 16'h0000, 2'h2);
      rd(10'h0c4, 16'h0000, 2'h0);
      wr(10'h3fc, 16'hffff, 2'h2);
      wr(10'h080, 16'hffff, 2'h0);
      rd(10'h080, 16'hbf01, 2'h0);
      wr(10'h07c, 16'hfff8, 2'h0);
      rd(10'h07c, 16'hfff8, 2'h0);
   endtask

   task automatic test_auto;
      wr(10'h07c, 16'h1100, 2'h0);
      repeat (4) @(posedge aclk);
      base = cnt;
      wr(10'h0c0, 16'h0001, 2'h0);
      repeat (4) @(posedge aclk);
      cmp_counts(7'h03);
      rd(10'h0c0, 16'h0001, 2'h0);
   endtask

   task automatic test_pins;
      logic [15:0] mn [4] = '{16'h4460, 16'h2234, 16'h6674, 16'h0010};
      logic [15:0] fd [4] = '{16'h2400, 16'h2701, 16'h3501, 16'h2e01};
      logic [3:0]  en = 4'b1101;
      logic [6:0]  e;
      for (int c = 0; c < 4; c++) begin
         wr(10'h07c, mn[c], 2'h0);
         wr(10'h080, fd[c], 2'h0);
         wr(10'h0c0, {15'h0, en[c]}, 2'h0);
         for (int p = 0; p < 3; p++) begin
            ab_pend <= 16'ha000 + 16'(c * 4 + p);
            repeat (4) @(posedge aclk);
            base = cnt;
            src.pulse(p, 1 + 2 * (p % 2));
            repeat (8) @(posedge aclk);
            e = expect_vec(mn[c], fd[c], en[c], p);
            cmp_counts(e);
            if (e[0])
               check("ab active", {16'h0, ab_act}, {16'h0, ab_pend});
            if (e[1])
               check("cd active", {16'h0, cd_act}, {16'h0, ~ab_pend});
         end
      end
   endtask

   task automatic test_sw;
      wr(10'h080, 16'h8901, 2'h0);
      wr(10'h07c, 16'h8882, 2'h0);
      repeat (3) @(posedge aclk);
      check("sw sync level", {25'h0, outs}, 32'h3f);
      check("ab active", {16'h0, ab_act}, {16'h0, ab_pend});
      wr(10'h07c, 16'h8880, 2'h0);
      repeat (3) @(posedge aclk);
      check("sw sync level", {25'h0, outs}, 32'h0);
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      mismatches++;
      complete_run;
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
      awaddr = 10'h000;
      araddr = 10'h000;
      wdata = 32'h0000_0000;
      ab_pend = 16'h0000;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      test_regs;
      test_auto;
      test_pins;
      test_sw;
      complete_run;
   end
endmodule // test_sync_source_select
`default_nettype wire
